// [hdl/t2t_pkg.sv]
// Shared constants and carrier types for the tag memory command block.
package t2t_pkg;
  localparam int unsigned BLOCK_BYTES   = 4;
  localparam int unsigned NUM_BLOCKS    = 64;
  localparam int unsigned BLK_W         = 6;
  localparam logic [7:0]  OP_WRITE      = 8'hA2;
  localparam logic [7:0]  OP_READ       = 8'h30;
  localparam logic [7:0]  ACK_CODE      = 8'hA0;
  localparam logic [7:0]  NACK_CODE     = 8'h00;
  localparam logic [7:0]  WIRE_WRITE    = 8'h40;
  localparam logic [7:0]  WIRE_READ     = 8'h7F;
  localparam logic [7:0]  CC_BLOCK      = 8'h03;
  localparam logic [7:0]  DATA_BLOCK    = 8'h04;
  localparam logic [7:0]  TLV_NDEF      = 8'h03;
  localparam logic [7:0]  TLV_LEN_LONG  = 8'hFF;
  localparam logic [7:0]  TLV_LEN_EMPTY = 8'h00;
  localparam logic [7:0]  TLV_TERM      = 8'hFE;
  // Capability container as shipped; bytes are arbitrary defaults.
  localparam logic [31:0] CC_RESET      = 32'hE110_0600;
  localparam int unsigned WRITE_LEN     = 6;
  localparam int unsigned READ_BLOCKS   = 4;
  localparam int unsigned READ_LEN      = 16;
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam int unsigned EE_WRITE_NS   = 1000;
  localparam int unsigned CLK_NS        = 25;
  localparam int unsigned EE_WRITE_CYC  = (EE_WRITE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {MODE_NORMAL = 2'b00, MODE_EXTENDED = 2'b01,
                            MODE_PASSTHRU = 2'b11} op_mode_type;

  typedef struct packed {
    logic [7:0] data;
    logic       first;
  } rx_byte_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tx_byte_type;
endpackage

// [hdl/t2t_tag_memory_access.sv]
// Tag memory with RF read/write interpreter, wired block port and passthrough buffer.
//
// Operation
// [RULE1] TLV records start with a one-byte type field.
// [RULE2] Length is one byte up to FEh, or FFh plus two bytes.
// [RULE3] Zero or missing length means no value bytes follow.
// [RULE4] NDEF message records use type 03h.
// [RULE5] Writers keep at least an empty NDEF record in memory.
// [RULE6] Writers put the NDEF record after lock and memory control records.
// [RULE7] Four-byte capability container always sits at block 03h.
// [RULE8] Shipped memory holds the container and an NDEF record at block 04h.
// [RULE9] Memory is four-byte blocks addressed by block number.
// [RULE10] RF write is A2h, block number, four data bytes.
// [RULE11] Successful write answers A0h; failure answers a negative code. Code answers A0h to an RF write dropped by a same-cycle wired write.
// [RULE12] Readers should read back the last written block.
// [RULE13] RF read is 30h plus start block; answer is sixteen bytes.
// [RULE14] Failed read answers one negative-acknowledge byte.
// [RULE15] RF memory access only in normal or extended mode.
// [RULE16] Wired write is 40, word address, four data bytes.
// [RULE17] Wired read is 7F, address, then four data bytes returned.
// [RULE18] Host sends sense command after switching to passthrough.
// [RULE19] Host enables passthrough and sets select response to 20h.
// [RULE20] Passthrough pushes every RF frame to the buffer, executing none. Code buffers only while i_selected is high; a full buffer drops bytes.
// [RULE21] Host handles sleep and sense state commands in passthrough.
// [RULE22] Host answers the activation request in passthrough.
// [RULE23] Out-of-range block answers negative code and changes nothing.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module t2t_byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push;
  wire              pop;

  // Full and empty come straight from the occupancy count.
  assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_reg != '0);
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_out_data  = mem_reg[rd_reg];

  // Pointers wrap because depth is a power of two.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage has no reset; the count guards against reading stale entries.
  always_ff @(posedge i_clk)
  begin
    if (push) mem_reg[wr_reg] <= i_in_data;
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module t2t_tag_memory_access (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire t2t_pkg::op_mode_type i_mode,
  input  wire logic                 i_selected,
  input  wire logic                 i_rx_valid,
  input  wire t2t_pkg::rx_byte_type i_rx,
  input  wire logic                 i_rx_end,
  output logic                      o_tx_valid,
  input  wire logic                 i_tx_ready,
  output t2t_pkg::tx_byte_type      o_tx,
  output logic                      o_buf_valid,
  input  wire logic                 i_buf_ready,
  output t2t_pkg::rx_byte_type      o_buf,
  output logic                      o_buf_overflow,
  input  wire logic                 i_host_valid,
  input  wire logic                 i_host_start,
  input  wire logic [7:0]           i_host_data,
  output logic                      o_host_rdata_valid,
  output logic [7:0]                o_host_rdata
);
  import t2t_pkg::*;

  // Sequencer states in near-Gray order along idle, collect, execute, wait, reply.
  // The spare codes only fall back to idle, so an upset cannot lock the sequencer.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_COLL  = 3'b001,
    ST_EXEC  = 3'b011,
    ST_WAIT  = 3'b010,
    ST_REPLY = 3'b110,
    ST_SKIP  = 3'b100
  } state_type;

  // Byte storage: one flat array, block n holds bytes 4n..4n+3. // [RULE9]
  logic [7:0]  mem_reg [NUM_BLOCKS*BLOCK_BYTES];
  state_type   state_reg;
  state_type   state_next;
  logic [7:0]  cmd_reg [WRITE_LEN];
  logic [2:0]  cnt_reg;
  logic [4:0]  tx_idx_reg;
  logic [4:0]  tx_len_reg;
  logic        tx_nack_reg;
  logic        tx_ack_reg;
  logic [15:0] wait_reg;
  logic [2:0]  h_cnt_reg;
  logic        h_rd_reg;
  logic [7:0]  h_addr_reg;
  logic        ovf_reg;

  // Passthrough routing and RF command decode.
  wire pass_on   = (i_mode == MODE_PASSTHRU) && i_selected; // [RULE20]
  wire mem_mode  = (i_mode == MODE_NORMAL) || (i_mode == MODE_EXTENDED); // [RULE15]
  wire rf_rx     = i_rx_valid && !pass_on;
  wire is_write  = (cmd_reg[0] == OP_WRITE) && (cnt_reg == 3'(WRITE_LEN)); // [RULE10]
  wire is_read   = (cmd_reg[0] == OP_READ) && (cnt_reg == 3'd2); // [RULE13]
  wire blk_ok    = (cmd_reg[1] < 8'(NUM_BLOCKS)); // [RULE23]
  wire do_write  = is_write && blk_ok && mem_mode;
  wire do_read   = is_read && blk_ok && mem_mode;
  wire tx_last   = (tx_idx_reg == tx_len_reg - 5'd1);
  wire tx_fire   = o_tx_valid && i_tx_ready;
  wire fifo_in_ready;

  // Read answer walks four blocks, wrapping at the end of memory.
  wire [7:0] rd_base = {cmd_reg[1][5:0], 2'b00};
  wire [7:0] rd_addr = rd_base + {3'b000, tx_idx_reg};
  wire [7:0] tx_byte = tx_nack_reg ? NACK_CODE : (tx_ack_reg ? ACK_CODE : mem_reg[rd_addr]);

  // Wired port: byte 0 mode, byte 1 word address (two words per block), then data.
  wire       h_byte  = i_host_valid && !i_host_start;
  wire [7:0] h_blk   = {1'b0, h_addr_reg[7:1]};
  wire       h_ok    = (h_blk < 8'(NUM_BLOCKS));
  wire [7:0] h_index = {h_blk[5:0], 2'b00} + {6'b0, 2'(h_cnt_reg - 3'd2)};
  wire       h_wr_en = h_byte && !h_rd_reg && (h_cnt_reg >= 3'd2) && (h_cnt_reg <= 3'd5) && h_ok;

  // Reply byte and its end flag travel together in one carrier.
  assign o_tx_valid     = (state_reg == ST_REPLY);
  assign o_tx           = '{data: tx_byte, last: tx_last};
  assign o_buf_overflow = ovf_reg;

  // Frames in passthrough with the tag selected skip the interpreter entirely. // [RULE20]
  t2t_byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_rx_valid && pass_on),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (i_rx),
    .o_out_valid (o_buf_valid),
    .i_out_ready (i_buf_ready),
    .o_out_data  (o_buf)
  );

  // Next state of the RF command sequencer.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (rf_rx) state_next = ST_COLL;
      ST_COLL:  if (i_rx_end) state_next = ST_EXEC;
      ST_EXEC:  state_next = do_write ? ST_WAIT : ST_REPLY;
      ST_WAIT:  if (wait_reg == 16'(EE_WRITE_CYC)) state_next = ST_REPLY;
      ST_REPLY: if (tx_fire && tx_last) state_next = ST_IDLE;
      ST_SKIP:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers; a late byte during reply is dropped.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      tx_idx_reg  <= '0;
      tx_len_reg  <= 5'd1;
      tx_nack_reg <= 1'b0;
      tx_ack_reg  <= 1'b0;
      for (int i = 0; i < WRITE_LEN; i++) cmd_reg[i] <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if ((state_reg == ST_IDLE) || (state_reg == ST_COLL))
      begin
        if (rf_rx && (i_rx.first || state_reg == ST_IDLE))
        begin
          cmd_reg[0] <= i_rx.data;
          cnt_reg    <= 3'd1;
        end
        else if (rf_rx && cnt_reg < 3'(WRITE_LEN))
        begin
          cmd_reg[cnt_reg] <= i_rx.data;
          cnt_reg          <= cnt_reg + 3'd1;
        end
      end
      if (state_reg == ST_EXEC)
      begin
        tx_idx_reg  <= '0;
        tx_nack_reg <= !(do_write || do_read); // [RULE11] [RULE14] [RULE23]
        tx_ack_reg  <= do_write; // [RULE11]
        tx_len_reg  <= do_read ? 5'(READ_LEN) : 5'd1; // [RULE13]
      end
      if (tx_fire) tx_idx_reg <= tx_idx_reg + 5'd1;
    end
  end

  // Programming delay counter. It only runs in the wait state and is cleared
  // everywhere else, so no stale count can carry into the next write.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      wait_reg <= '0;
    else if (state_reg == ST_WAIT)
      wait_reg <= wait_reg + 16'd1;
    else
      wait_reg <= '0;
  end

  // Overflow stays set until reset: a lost passthrough byte cannot be recovered. // [RULE20]
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ovf_reg <= 1'b0;
    else if (i_rx_valid && pass_on && !fifo_in_ready)
      ovf_reg <= 1'b1;
  end

  // Wired transaction tracking and read data.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      h_cnt_reg          <= '0;
      h_rd_reg           <= 1'b0;
      h_addr_reg         <= '0;
      o_host_rdata_valid <= 1'b0;
      o_host_rdata       <= '0;
    end
    else
    begin
      o_host_rdata_valid <= 1'b0;
      if (i_host_valid && i_host_start)
      begin
        h_rd_reg  <= (i_host_data == WIRE_READ); // [RULE17]
        h_cnt_reg <= (i_host_data == WIRE_READ || i_host_data == WIRE_WRITE) ? 3'd1 : 3'd7; // [RULE16]
      end
      else if (h_byte && h_cnt_reg != 3'd7)
      begin
        if (h_cnt_reg == 3'd1) h_addr_reg <= i_host_data;
        h_cnt_reg <= h_cnt_reg + 3'd1;
        if (h_rd_reg && h_cnt_reg >= 3'd2 && h_cnt_reg <= 3'd5)
        begin
          o_host_rdata_valid <= 1'b1; // [RULE17]
          o_host_rdata       <= h_ok ? mem_reg[h_index] : 8'h00;
        end
      end
    end
  end

  // Memory preload: container at block 03h, empty NDEF record at 04h. // [RULE7] [RULE8]
  // The RF write lands once the programming delay has elapsed; the wired
  // port wins a same-cycle collision since the reader can always retry.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      for (int i = 0; i < NUM_BLOCKS*BLOCK_BYTES; i++) mem_reg[i] <= 8'h00;
      for (int b = 0; b < BLOCK_BYTES; b++)
        mem_reg[CC_BLOCK*BLOCK_BYTES+b] <= CC_RESET[31-8*b -: 8]; // [RULE7]
      mem_reg[DATA_BLOCK*BLOCK_BYTES]   <= TLV_NDEF; // [RULE4] [RULE1]
      mem_reg[DATA_BLOCK*BLOCK_BYTES+1] <= TLV_LEN_EMPTY; // [RULE3] [RULE2]
      mem_reg[DATA_BLOCK*BLOCK_BYTES+2] <= TLV_TERM;
    end
    else if (h_wr_en)
      mem_reg[h_index] <= i_host_data; // [RULE16]
    else if (state_reg == ST_WAIT && wait_reg == 16'(EE_WRITE_CYC))
    begin
      for (int b = 0; b < BLOCK_BYTES; b++)
        mem_reg[{cmd_reg[1][5:0], 2'(b)}] <= cmd_reg[2+b]; // [RULE10]
    end
  end
endmodule

`default_nettype wire

// [sim/t2t_reader_model.sv]
// Behavioural RF reader that sends command frames and collects replies.
`timescale 1ns/1ps
`default_nettype none
module t2t_reader_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_tx_valid,
  input  wire t2t_pkg::tx_byte_type i_tx,
  output logic                      o_tx_ready,
  output logic                      o_rx_valid,
  output t2t_pkg::rx_byte_type      o_rx,
  output logic                      o_rx_end
);
  import t2t_pkg::*;
  logic [7:0] got [$];
  int         replies = 0;
  // Idle lines start low; the data bus is scrambled between bytes.
  initial
  begin
    o_tx_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx       = '0;
    o_rx_end   = 1'b0;
  end
  // Ready stalls at random, about one cycle in four, so that some reply bytes must wait.
  always @(negedge i_clk)
    o_tx_ready <= ($urandom_range(0, 3) != 0);
  // A reply counts as whole once its last byte is taken.
  always @(posedge i_clk)
  begin
    if (i_tx_valid && o_tx_ready)
    begin
      got.push_back(i_tx.data);
      replies += int'(i_tx.last);
    end
  end
  // One strobe per byte, first flag on byte zero, then the end pulse.
  task automatic send(input logic [7:0] f [$]);
    foreach (f[k])
    begin
      @(negedge i_clk);
      o_rx_valid = 1'b1;
      o_rx       = '{data: f[k], first: (k == 0)};
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      o_rx.data  = ~f[k];
    end
    @(negedge i_clk);
    o_rx_end = 1'b1;
    @(negedge i_clk);
    o_rx_end = 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/t2t_tag_memory_access_props.sv]
// Port-level assertions and covers for the tag memory command block.
`timescale 1ns/1ps
`default_nettype none
module t2t_tag_memory_access_props (
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  input wire t2t_pkg::op_mode_type i_mode,
  input wire logic                 i_selected,
  input wire logic                 i_rx_valid,
  input wire logic                 i_rx_end,
  input wire logic                 o_tx_valid,
  input wire logic                 i_tx_ready,
  input wire t2t_pkg::tx_byte_type o_tx,
  input wire logic                 o_buf_valid,
  input wire logic                 i_buf_ready,
  input wire t2t_pkg::rx_byte_type o_buf,
  input wire logic                 o_buf_overflow,
  input wire logic                 i_host_valid,
  input wire logic                 i_host_start,
  input wire logic                 o_host_rdata_valid
);
  import t2t_pkg::*;
  // Passthrough only takes over once the tag is selected.
  wire pass_sel = (i_mode == MODE_PASSTHRU) && i_selected;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////////
  // Stalled outputs must not move, or the consumer would lose a byte.
  a_tx_holds: assert property (o_tx_valid && !i_tx_ready |=> $stable(o_tx))
    else $error("reply byte changed while stalled");
  a_tx_last_ends: assert property (
    o_tx_valid && o_tx.last && i_tx_ready |=> !o_tx_valid)
    else $error("reply went on after its last byte");
  a_one_byte_code: assert property ($rose(o_tx_valid) && o_tx.last |->
    o_tx.data == ACK_CODE || o_tx.data == NACK_CODE) else $error("bad one-byte reply");
  a_mode_refused: assert property (
    i_rx_end && !o_tx_valid && i_mode == MODE_PASSTHRU && !i_selected
    |-> ##2 o_tx_valid && o_tx.data == NACK_CODE) else $error("no refusal");
  a_pass_push: assert property (i_rx_valid && pass_sel |=> o_buf_valid)
    else $error("passthrough byte not buffered");
  a_pass_no_exec: assert property (pass_sel [*3] |-> !o_tx_valid)
    else $error("tag answered in passthrough");
  a_buf_holds: assert property (
    o_buf_valid && !i_buf_ready |=> o_buf_valid && $stable(o_buf))
    else $error("buffer output moved while stalled");
  a_rdata_cause: assert property (o_host_rdata_valid |-> $past(i_host_valid))
    else $error("wired data without a byte");
  a_start_no_data: assert property (
    i_host_valid && i_host_start |=> !o_host_rdata_valid)
    else $error("wired data after a mode byte");
  // Main scenarios: long read reply, buffer overflow, wired read burst.
  c_read_reply: cover property ($rose(o_tx_valid) && !o_tx.last);
  c_overflow: cover property ($rose(o_buf_overflow));
  c_host_read: cover property (o_host_rdata_valid ##1 o_host_rdata_valid);
endmodule
bind t2t_tag_memory_access t2t_tag_memory_access_props t2t_tag_memory_access_props_inst (
  .i_clk, .i_rstn, .i_mode, .i_selected, .i_rx_valid, .i_rx_end, .o_tx_valid, .i_tx_ready,
  .o_tx, .o_buf_valid, .i_buf_ready, .o_buf, .o_buf_overflow, .i_host_valid, .i_host_start,
  .o_host_rdata_valid
);
`default_nettype wire

// [sim/test_t2t_tag_memory_access.sv]
// Self-checking testbench for the tag memory command block.
`timescale 1ns/1ps
`default_nettype none
module test_t2t_tag_memory_access;
  import t2t_pkg::*;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_selected = 1'b0, i_buf_ready = 1'b0;
  logic        i_host_valid = 1'b0, i_host_start = 1'b0;
  logic [7:0]  i_host_data = 8'h00;
  op_mode_type i_mode = MODE_NORMAL;
  logic        i_rx_valid, i_rx_end, o_tx_valid, i_tx_ready, o_buf_valid, o_buf_overflow;
  logic        o_host_rdata_valid;
  logic [7:0]  o_host_rdata, mem [256], host_q [$];
  rx_byte_type i_rx, o_buf;
  tx_byte_type o_tx;
  int          fails = 0, checks = 0, cycles = 0;
  t2t_tag_memory_access t2t_tag_memory_access_inst (.i_clk, .i_rstn, .i_mode, .i_selected,
    .i_rx_valid, .i_rx, .i_rx_end, .o_tx_valid, .i_tx_ready, .o_tx, .o_buf_valid, .i_buf_ready,
    .o_buf, .o_buf_overflow, .i_host_valid, .i_host_start, .i_host_data, .o_host_rdata_valid,
    .o_host_rdata);
  t2t_reader_model t2t_reader_model_inst (.i_clk, .i_tx_valid(o_tx_valid), .i_tx(o_tx),
    .o_tx_ready(i_tx_ready), .o_rx_valid(i_rx_valid), .o_rx(i_rx), .o_rx_end(i_rx_end));
  // Clock at 40 MHz.
  always #12.5 i_clk = ~i_clk;
  // Collect wired read bytes and cut a hang short.
  always @(posedge i_clk)
  begin
    cycles++;
    if (o_host_rdata_valid === 1'b1)
      host_q.push_back(o_host_rdata);
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      fails++;
    end
  endtask
  // Sends a frame and compares the whole reply with the model's bytes.
  task automatic rf(input logic [7:0] f [$], input logic [7:0] e [$]);
    int n;
    n = t2t_reader_model_inst.replies;
    t2t_reader_model_inst.got.delete();
    t2t_reader_model_inst.send(f);
    for (int w = 0; w < 400 && t2t_reader_model_inst.replies == n; w++)
      @(negedge i_clk);
    check("reply length", 8'(e.size()), 8'(t2t_reader_model_inst.got.size()));
    foreach (e[k])
      check("reply byte", e[k], t2t_reader_model_inst.got[k]);
  endtask
  task automatic rf_read(input logic [7:0] blk, input logic ok);
    logic [7:0] e [$];
    for (int n = 0; n < READ_LEN; n++)
      e.push_back(mem[(blk * 4 + n) % 256]);
    if (!ok || blk >= NUM_BLOCKS)
      e = '{NACK_CODE};
    rf('{OP_READ, blk}, e);
  endtask
  task automatic rf_write(input logic [7:0] blk, input logic [31:0] d);
    logic ok;
    ok = blk < NUM_BLOCKS;
    rf('{OP_WRITE, blk, d[31:24], d[23:16], d[15:8], d[7:0]},
       '{ok ? ACK_CODE : NACK_CODE});
    for (int n = 0; n < 4 && ok; n++)
      mem[blk * 4 + n] = d[31 - 8 * n -: 8];
  endtask
  // Wired sequence: mode byte flagged as start, then the rest back to back.
  task automatic host_seq(input logic [7:0] b [$]);
    foreach (b[k])
    begin
      @(negedge i_clk);
      i_host_valid = 1'b1;
      i_host_start = (k == 0);
      i_host_data  = b[k];
    end
    @(negedge i_clk);
    i_host_valid = 1'b0;
    i_host_start = 1'b0;
    i_host_data  = ~i_host_data;
  endtask
  task automatic host_read(input logic [7:0] blk);
    host_q.delete();
    host_seq('{WIRE_READ, 8'(blk * 2), 8'h00, 8'h00, 8'h00, 8'h00});
    repeat (2) @(negedge i_clk);
    check("wired count", 8'd4, 8'(host_q.size()));
    foreach (host_q[n])
      check("wired byte", mem[blk * 4 + n], host_q[n]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: shipped memory, RF access in each mode, wired port, passthrough.
  initial
  begin
    logic [7:0]  blk, frame [$];
    logic [31:0] d;
    void'($urandom(32'h89d2_fa61));
    for (int a = 0; a < 256; a++)
      mem[a] = 8'h00;
    {mem[12], mem[13], mem[14], mem[15]} = CC_RESET;
    {mem[16], mem[17], mem[18], mem[19]} = {TLV_NDEF, TLV_LEN_EMPTY, TLV_TERM, 8'h00};
    repeat (5) @(posedge i_clk);
    @(negedge i_clk);
    i_rstn = 1'b1;
    rf_read(CC_BLOCK, 1'b1);
    rf_read(8'd62, 1'b1);
    for (int m = 0; m < 2; m++)
    begin
      i_mode = m ? MODE_EXTENDED : MODE_NORMAL;
      // Block 04h keeps the empty NDEF record with nothing ahead of it.
      blk = 8'($urandom_range(5, 63));
      rf_write(blk, $urandom);
      rf_read(blk, 1'b1);
    end
    rf_write(8'($urandom_range(64, 255)), $urandom);
    rf_read(8'd64, 1'b1);
    blk = 8'($urandom_range(5, 63));
    d = $urandom;
    host_seq('{WIRE_WRITE, 8'(blk * 2), d[31:24], d[23:16], d[15:8], d[7:0]});
    {mem[blk * 4], mem[blk * 4 + 1], mem[blk * 4 + 2], mem[blk * 4 + 3]} = d;
    rf_read(blk, 1'b1);
    rf_write(blk, $urandom);
    host_read(blk);
    i_mode = MODE_PASSTHRU;
    rf_read(DATA_BLOCK, 1'b0);
    // The host has sent the tag back to sense and the reader selected it again.
    i_selected = 1'b1;
    // A memory opcode leads the frame: in passthrough only the host may answer it.
    t2t_reader_model_inst.got.delete();
    frame.push_back(OP_READ);
    repeat (WRITE_LEN - 1) frame.push_back(8'($urandom));
    t2t_reader_model_inst.send(frame);
    check("overflow", 8'd1, {7'd0, o_buf_overflow});
    for (int k = 0; k < FIFO_DEPTH; k++)
    begin
      check("buffer valid", 8'd1, {7'd0, o_buf_valid});
      check("buffer byte", frame[k], o_buf.data);
      check("buffer first", 8'(k == 0), {7'd0, o_buf.first});
      i_buf_ready = 1'b1;
      @(negedge i_clk);
    end
    i_buf_ready = 1'b0;
    check("buffer empty", 8'd0, {7'd0, o_buf_valid});
    check("passthrough reply", 8'd0, 8'(t2t_reader_model_inst.got.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
